/* hdl/pwm_auto_reload_timer.sv */
// Purpose: 8-bit auto-reload timer with four PWM outputs and two captures
// Assumes: APB slave on sys_clk; haltMode is a level on the same clock
// Notes:   Registers sit at byte address four times their index
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pwm_auto_reload_timer (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic haltMode,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extClkPin,
   input wire logic [1:0] captureInputPin,
   output logic [3:0] modulatedOutputPin,
   output logic [3:0] modulatedOutputOeN,
   output logic overflowIrq,
   output logic captureIrq,
   output logic wakeRequest
);
   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   art_pkg::ctrl_status_t ctrlReg;
   art_pkg::pulse_ctrl_t pulseReg;
   art_pkg::bus_state_t busStateReg;
   art_pkg::bus_state_t busStateNext;
   logic [7:0] counterReg;
   logic [7:0] counterNext;
   logic [7:0] reloadReg;
   logic [7:0] dutyReg [4];
   logic [7:0] compareReg [4];
   logic [7:0] compareNext [4];
   logic [1:0] edgeSelReg;
   logic [1:0] capIrqEnReg;
   logic [1:0] capFlagReg;
   logic [1:0] capFlagNext;
   logic [7:0] captureReg [2];
   logic [2:0] snapFlagReg;
   logic [3:0] pwmNext;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic [7:0] index;
   logic mapped;
   logic accept;
   logic fire;
   logic wrEn;
   logic rdFire;
   logic [7:0] wByte;
   logic [7:0] rdByte;

   assign index = art_pkg::word_index(paddr);
   assign mapped = (index >= art_pkg::IDX_DUTY3) && (index <= art_pkg::IDX_CAP2);
   assign accept = psel && penable && (busStateReg == art_pkg::BUS_IDLE);
   assign fire = psel && penable && (busStateReg == art_pkg::BUS_RESP);
   assign wrEn = fire && pwrite && pstrb[0] && mapped;
   assign rdFire = fire && !pwrite && mapped;
   assign wByte = pwdata[7:0];

   logic wrCtrl;
   logic wrCounter;
   logic wrReload;
   logic wrPulse;
   logic wrCapCtrl;
   logic forceLoad;
   logic rdCtrl;
   logic [1:0] rdCapture;

   assign wrCtrl = wrEn && (index == art_pkg::IDX_CTRL_STATUS);
   assign wrCounter = wrEn && (index == art_pkg::IDX_COUNTER);
   assign wrReload = wrEn && (index == art_pkg::IDX_RELOAD);
   assign wrPulse = wrEn && (index == art_pkg::IDX_PULSE_CTRL);
   assign wrCapCtrl = wrEn && (index == art_pkg::IDX_CAP_CTRL);
   assign forceLoad = wrCtrl && wByte[2];
   assign rdCtrl = rdFire && (index == art_pkg::IDX_CTRL_STATUS);
   assign rdCapture[0] = rdFire && (index == art_pkg::IDX_CAP1);
   assign rdCapture[1] = rdFire && (index == art_pkg::IDX_CAP2);

   always_comb begin
      case (index)
         art_pkg::IDX_DUTY3: rdByte = dutyReg[3];
         art_pkg::IDX_DUTY2: rdByte = dutyReg[2];
         art_pkg::IDX_DUTY1: rdByte = dutyReg[1];
         art_pkg::IDX_DUTY0: rdByte = dutyReg[0];
         art_pkg::IDX_PULSE_CTRL: rdByte = pulseReg;
         // Force reload always reads as zero
         art_pkg::IDX_CTRL_STATUS: rdByte = {ctrlReg[7:3], 1'b0, ctrlReg[1:0]};
         art_pkg::IDX_COUNTER: rdByte = counterReg;
         art_pkg::IDX_RELOAD: rdByte = reloadReg;
         art_pkg::IDX_CAP_CTRL: rdByte = {2'h0, edgeSelReg, capIrqEnReg, capFlagReg};
         art_pkg::IDX_CAP1: rdByte = captureReg[0];
         art_pkg::IDX_CAP2: rdByte = captureReg[1];
         default: rdByte = art_pkg::RESET_BYTE;
      endcase
   end

   always_comb begin
      case (busStateReg)
         art_pkg::BUS_IDLE: busStateNext = accept ? art_pkg::BUS_RESP : art_pkg::BUS_IDLE;
         art_pkg::BUS_RESP: busStateNext = fire ? art_pkg::BUS_IDLE : art_pkg::BUS_RESP;
         default: busStateNext = art_pkg::BUS_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pinRise;
   logic [2:0] pinFall;

   pin_sync #(.W(3)) u_pin_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .pinIn({captureInputPin, extClkPin}),
      .rise(pinRise),
      .fall(pinFall)
   );

   // ------------------------------------------------------------
   // Clock source, prescaler and counter
   // ------------------------------------------------------------
   logic running;
   logic sourceTick;
   logic counterTick;
   logic overflowEvent;
   logic prescaleClear;

   // Halt stops counting; software is expected to drop count enable first
   assign running = ctrlReg.countEnable && !haltMode;
   assign sourceTick = ctrlReg.extClk ? pinRise[0] : 1'b1;
   assign prescaleClear = forceLoad || wrCounter;

   tap_prescaler u_tap_prescaler (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .clear(prescaleClear),
      .inTick(running && sourceTick),
      .tapSelect(ctrlReg.prescaleSelect),
      .outTick(counterTick)
   );

   assign overflowEvent = counterTick && (counterReg == art_pkg::COUNT_TOP);

   always_comb begin
      if (wrCounter) begin
         counterNext = wByte;
      end else if (forceLoad) begin
         counterNext = reloadReg;
      end else if (overflowEvent) begin
         counterNext = reloadReg;
      end else if (counterTick) begin
         counterNext = counterReg + 8'h01;
      end else begin
         counterNext = counterReg;
      end
   end

   // ------------------------------------------------------------
   // Compare and PWM levels
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         compareNext[i] = overflowEvent ? dutyReg[i] : compareReg[i];
         // Levels track the next counter so they switch with the reload
         pwmNext[i] = (counterNext <= compareNext[i]) ^ pulseReg.outputPolarity[i];
      end
   end

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   logic overflowNext;
   logic [1:0] captureEdge;
   logic [1:0] captureEvent;
   logic [1:0] clearCapFlag;
   logic capIrqNext;

   // A flag clears only if the read actually returned it as set
   assign overflowNext = overflowEvent || (ctrlReg.overflowFlag && !(rdCtrl && snapFlagReg[0]));
   assign captureEdge = (edgeSelReg & pinRise[2:1]) | (~edgeSelReg & pinFall[2:1]);
   assign clearCapFlag = rdCapture & snapFlagReg[2:1];
   assign captureEvent = captureEdge & (~capFlagReg | clearCapFlag);
   assign capFlagNext = captureEvent | (capFlagReg & ~clearCapFlag);
   assign capIrqNext = |(capFlagNext & capIrqEnReg);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busStateReg <= art_pkg::BUS_IDLE;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         snapFlagReg <= 3'h0;
      end else if (clkEn) begin
         busStateReg <= busStateNext;
         pready <= accept;
         if (accept) begin
            prdata <= {24'h000000, rdByte};
            pslverr <= !mapped;
            snapFlagReg <= {capFlagReg, ctrlReg.overflowFlag};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrlReg <= art_pkg::RESET_BYTE;
         pulseReg <= art_pkg::RESET_BYTE;
         reloadReg <= art_pkg::RESET_BYTE;
         counterReg <= art_pkg::RESET_BYTE;
      end else if (clkEn) begin
         counterReg <= counterNext;
         if (wrCtrl) begin
            ctrlReg <= {wByte[7:3], 1'b0, wByte[1], overflowNext};
         end else begin
            ctrlReg.overflowFlag <= overflowNext;
         end
         if (wrPulse) begin
            pulseReg <= wByte;
         end
         if (wrReload) begin
            reloadReg <= wByte;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            dutyReg[i] <= art_pkg::RESET_BYTE;
            compareReg[i] <= art_pkg::RESET_BYTE;
         end
      end else if (clkEn) begin
         for (int i = 0; i < 4; i++) begin
            compareReg[i] <= compareNext[i];
            if (wrEn && index == 8'(art_pkg::IDX_DUTY0 - 8'(i))) begin
               dutyReg[i] <= wByte;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         edgeSelReg <= 2'h0;
         capIrqEnReg <= 2'h0;
         capFlagReg <= 2'h0;
         captureReg[0] <= art_pkg::RESET_BYTE;
         captureReg[1] <= art_pkg::RESET_BYTE;
      end else if (clkEn) begin
         capFlagReg <= capFlagNext;
         if (wrCapCtrl) begin
            edgeSelReg <= wByte[5:4];
            capIrqEnReg <= wByte[3:2];
         end
         for (int c = 0; c < 2; c++) begin
            if (captureEvent[c]) begin
               captureReg[c] <= counterReg;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Pin and request outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         modulatedOutputPin <= 4'h0;
         modulatedOutputOeN <= 4'hf;
         overflowIrq <= 1'b0;
         captureIrq <= 1'b0;
         wakeRequest <= 1'b0;
      end else if (clkEn) begin
         // Levels hold during halt
         if (!haltMode) begin
            modulatedOutputPin <= pwmNext;
         end
         modulatedOutputOeN <= ~pulseReg.outputEnable;
         overflowIrq <= overflowNext && ctrlReg.overflowIrqEnable;
         captureIrq <= capIrqNext;
         wakeRequest <= haltMode && capIrqNext;
      end
   end
endmodule // pwm_auto_reload_timer
`default_nettype wire

/* hdl/art_pkg.sv */
// Purpose: Shared constants and types of the PWM auto-reload timer
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register offsets are indexes; byte address is four times the index
package art_pkg;

   // ------------------------------------------------------------
   // Register indexes
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_DUTY3 = 8'h73;
   localparam logic [7:0] IDX_DUTY2 = 8'h74;
   localparam logic [7:0] IDX_DUTY1 = 8'h75;
   localparam logic [7:0] IDX_DUTY0 = 8'h76;
   localparam logic [7:0] IDX_PULSE_CTRL = 8'h77;
   localparam logic [7:0] IDX_CTRL_STATUS = 8'h78;
   localparam logic [7:0] IDX_COUNTER = 8'h79;
   localparam logic [7:0] IDX_RELOAD = 8'h7a;
   localparam logic [7:0] IDX_CAP_CTRL = 8'h7b;
   localparam logic [7:0] IDX_CAP1 = 8'h7c;
   localparam logic [7:0] IDX_CAP2 = 8'h7d;

   // ------------------------------------------------------------
   // Reset values and fixed figures
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] COUNT_TOP = 8'hff;
   localparam logic [6:0] PRESCALE_CLEAR = 7'h00;

   // ------------------------------------------------------------
   // Field layouts
   // ------------------------------------------------------------
   typedef struct packed {
      logic extClk;
      logic [2:0] prescaleSelect;
      logic countEnable;
      logic forceReload;
      logic overflowIrqEnable;
      logic overflowFlag;
   } ctrl_status_t;

   typedef struct packed {
      logic [3:0] outputEnable;
      logic [3:0] outputPolarity;
   } pulse_ctrl_t;

   typedef struct packed {
      logic [1:0] reserved;
      logic [1:0] edgeSelect;
      logic [1:0] irqEnable;
      logic [1:0] captureFlag;
   } cap_ctrl_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_RESP = 1'b1
   } bus_state_t;

   // Index of a word address, or all ones when the address is not aligned or bit 11 or 10 is set
   function automatic logic [7:0] word_index(input logic [11:0] addr);
      word_index = (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) ? addr[9:2] : 8'hff;
   endfunction

endpackage

/* hdl/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter and edge pulses
// Assumes: Inputs are asynchronous to sys_clk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] s1Reg;
   logic [W-1:0] s2Reg;
   logic [W-1:0] s3Reg;
   logic [W-1:0] stableReg;
   logic [W-1:0] agree;
   logic [W-1:0] stableNext;

   assign agree = ~(s2Reg ^ s3Reg);
   assign stableNext = (agree & s3Reg) | (~agree & stableReg);
   assign rise = agree & s3Reg & ~stableReg;
   assign fall = agree & ~s3Reg & stableReg;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s1Reg <= '0;
         s2Reg <= '0;
         s3Reg <= '0;
         stableReg <= '0;
      end else if (clkEn) begin
         s1Reg <= pinIn;
         s2Reg <= s1Reg;
         s3Reg <= s2Reg;
         stableReg <= stableNext;
      end
   end
endmodule // pin_sync
`default_nettype wire

/* hdl/tap_prescaler.sv */
// Purpose: Seven-bit prescaler with eight power-of-two taps
// Assumes: inTick marks one period of the selected input clock
// Notes:   Tap zero passes every input tick through
`timescale 1ns/1ns
`default_nettype none
module tap_prescaler (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic clear,
   input wire logic inTick,
   input wire logic [2:0] tapSelect,
   output logic outTick
);
   logic [6:0] preReg;
   logic [6:0] preNext;
   logic [6:0] mask;

   assign mask = 7'((8'h01 << tapSelect) - 8'h01);
   assign outTick = inTick && ((preReg & mask) == mask);
   assign preNext = clear ? art_pkg::PRESCALE_CLEAR : (inTick ? preReg + 7'h01 : preReg);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         preReg <= art_pkg::PRESCALE_CLEAR;
      end else if (clkEn) begin
         preReg <= preNext;
      end
   end
endmodule // tap_prescaler
`default_nettype wire

/* verification/pwm_auto_reload_timer_assertions.sv */
// Purpose: Concurrent checks on the timer's bus, interrupt and pin ports
// Assumes: clkEn drops only while the bus is idle
// Notes:   Helper registers mirror interrupt enables and output enables written over the bus
`timescale 1ns/1ns
`default_nettype none
module pwm_auto_reload_timer_assertions (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic haltMode,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [3:0] modulatedOutputPin,
   input wire logic [3:0] modulatedOutputOeN,
   input wire logic overflowIrq,
   input wire logic captureIrq,
   input wire logic wakeRequest
);
   // ----------------------------------------
   // Mirrors of software settings
   // ----------------------------------------
   wire [11:0] ctrlAddr = {2'h0, art_pkg::IDX_CTRL_STATUS, 2'h0};
   wire [11:0] capAddr = {2'h0, art_pkg::IDX_CAP_CTRL, 2'h0};
   wire [11:0] pulseAddr = {2'h0, art_pkg::IDX_PULSE_CTRL, 2'h0};
   wire xferDone = psel & penable & pready;
   wire wrDone = xferDone & pwrite & pstrb[0];
   logic ovfEnReg;
   logic [1:0] capEnReg;
   logic [3:0] oeExpReg;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ovfEnReg <= 1'b0;
         capEnReg <= 2'h0;
         oeExpReg <= 4'hf;
      end else begin
         if (wrDone && paddr == ctrlAddr) ovfEnReg <= pwdata[1];
         if (wrDone && paddr == capAddr) capEnReg <= pwdata[3:2];
         if (wrDone && paddr == pulseAddr) oeExpReg <= ~pwdata[7:4];
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_ready_one_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
      psel && penable && !pready |=> pready) else $error("pready late");
   a_ready_one_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pready |=> !pready) else $error("pready longer than one cycle");
   a_force_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      xferDone && !pwrite && paddr == ctrlAddr |-> prdata[2] == 1'b0) else $error("force reload read as one");
   a_ovf_irq_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
      overflowIrq |-> $past(ovfEnReg)) else $error("overflow irq while disabled");
   a_cap_irq_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
      captureIrq |-> $past(capEnReg) != 2'h0) else $error("capture irq while disabled");
   a_wake_needs_halt: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !$past(haltMode) |-> !wakeRequest) else $error("wake outside halt");
   a_wake_needs_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wakeRequest |-> captureIrq) else $error("wake without capture irq");
   a_halt_freezes_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
      haltMode |=> $stable(modulatedOutputPin)) else $error("pwm pin moved in halt");
   a_oe_follows_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wrDone && paddr == pulseAddr |-> ##2 modulatedOutputOeN == oeExpReg) else $error("output enable wrong");
   a_reset_outputs: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> modulatedOutputOeN == 4'hf && !overflowIrq && !captureIrq && !pready)
      else $error("outputs not at reset level");
endmodule // pwm_auto_reload_timer_assertions

bind pwm_auto_reload_timer pwm_auto_reload_timer_assertions pwm_auto_reload_timer_assertions_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .haltMode(haltMode), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .modulatedOutputPin(modulatedOutputPin), .modulatedOutputOeN(modulatedOutputOeN),
   .overflowIrq(overflowIrq), .captureIrq(captureIrq), .wakeRequest(wakeRequest));
`default_nettype wire

/* verification/pin_stimulus_model.sv */
// Purpose: Far-side pins: external event clock and two capture inputs
// Assumes: Pulses are slow enough for the three-stage synchroniser
// Notes:   Event clock idles low between bursts
`timescale 1ns/1ns
`default_nettype none
module pin_stimulus_model (
   input wire logic sys_clk,
   output logic extClkPin,
   output logic [1:0] captureInputPin
);
   initial begin
      extClkPin = 1'b0;
      captureInputPin = 2'b10;
   end

   // Each event is four cycles high and four low; four cycles of settle time follow the last event
   task automatic event_pulses(input int n);
      repeat (n) begin
         extClkPin <= 1'b1;
         repeat (4) @(posedge sys_clk);
         extClkPin <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic drive_capture(input int ch, input logic level);
      captureInputPin[ch] <= level;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule // pin_stimulus_model
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Register-level test of the auto-reload timer
// Assumes: Event clock from the pin model steps the counter exactly
// Notes:   Expected PWM levels come from a small counter model here
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clkEn;
   logic haltMode;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic extClkPin;
   logic [1:0] captureInputPin;
   logic [3:0] modulatedOutputPin;
   logic [3:0] modulatedOutputOeN;
   logic overflowIrq;
   logic captureIrq;
   logic wakeRequest;
   int failures = 0;
   int nCompared = 0;
   logic [7:0] duty [4] = '{8'hfd, 8'hfe, 8'hff, 8'hfc};
   logic [7:0] cmp [4] = '{default: 8'h00};
   logic [3:0] pol = 4'h5;
   logic [7:0] cnt;
   logic [7:0] q;
   logic err;

   always #25 sys_clk = ~sys_clk;

   pwm_auto_reload_timer pwm_auto_reload_timer_i (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
      .haltMode(haltMode), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .extClkPin(extClkPin), .captureInputPin(captureInputPin), .modulatedOutputPin(modulatedOutputPin),
      .modulatedOutputOeN(modulatedOutputOeN), .overflowIrq(overflowIrq), .captureIrq(captureIrq),
      .wakeRequest(wakeRequest));
   pin_stimulus_model farPins (.sys_clk(sys_clk), .extClkPin(extClkPin), .captureInputPin(captureInputPin));

   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", nCompared, failures);
      if (failures == 0 && nCompared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      nCompared++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask

   task automatic check_pins(input logic [3:0] got, input logic [3:0] exp);
      nCompared++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask

   task automatic apb_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         failures++;
         tally_and_finish();
      end
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb_xfer(1'b1, idx, d);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      apb_xfer(1'b0, idx, 8'h00);
      check_byte(q, exp);
   endtask

   function automatic logic [3:0] pwm_exp(input logic [7:0] c);
      for (int i = 0; i < 4; i++) pwm_exp[i] = (c <= cmp[i]) ^ pol[i];
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clkEn <= 1'b1;
      haltMode <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h000;
      pwdata <= 32'h0;
      pstrb <= 4'h1;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      for (int i = 8'h73; i <= 8'h7d; i++) rd_chk(i[7:0], art_pkg::RESET_BYTE);
      check_pins(modulatedOutputOeN, 4'hf);
      apb_xfer(1'b0, 8'h00, 8'h00);
      check_byte({7'h0, err}, 8'h01);
      wr(art_pkg::IDX_CAP1, 8'h55);
      rd_chk(art_pkg::IDX_CAP1, 8'h00);
      wr(art_pkg::IDX_COUNTER, 8'h10);
      rd_chk(art_pkg::IDX_COUNTER, 8'h10);
      // A write with its byte strobe low must leave the counter alone
      pstrb <= 4'h0;
      wr(art_pkg::IDX_COUNTER, 8'h77);
      pstrb <= 4'h1;
      rd_chk(art_pkg::IDX_COUNTER, 8'h10);
      // Event counting from the external pin
      wr(art_pkg::IDX_RELOAD, 8'hfd);
      wr(art_pkg::IDX_CTRL_STATUS, 8'h8c);
      rd_chk(art_pkg::IDX_CTRL_STATUS, 8'h88);
      rd_chk(art_pkg::IDX_COUNTER, 8'hfd);
      farPins.event_pulses(2);
      rd_chk(art_pkg::IDX_COUNTER, 8'hff);
      rd_chk(art_pkg::IDX_CTRL_STATUS, 8'h88);
      farPins.event_pulses(1);
      rd_chk(art_pkg::IDX_COUNTER, 8'hfd);
      rd_chk(art_pkg::IDX_CTRL_STATUS, 8'h89);
      rd_chk(art_pkg::IDX_CTRL_STATUS, 8'h88);
      wr(art_pkg::IDX_CTRL_STATUS, 8'h8a);
      farPins.event_pulses(3);
      check_pins({3'h0, overflowIrq}, 4'h1);
      rd_chk(art_pkg::IDX_CTRL_STATUS, 8'h8b);
      repeat (3) @(posedge sys_clk);
      check_pins({3'h0, overflowIrq}, 4'h0);
      wr(art_pkg::IDX_CTRL_STATUS, 8'h88);
      farPins.event_pulses(3);
      check_pins({3'h0, overflowIrq}, 4'h0);
      rd_chk(art_pkg::IDX_CTRL_STATUS, 8'h89);
      wr(art_pkg::IDX_CTRL_STATUS, 8'h9c);
      farPins.event_pulses(3);
      rd_chk(art_pkg::IDX_COUNTER, 8'hfe);
      // Clock enable low freezes synchroniser, prescaler and counter
      clkEn <= 1'b0;
      farPins.event_pulses(2);
      clkEn <= 1'b1;
      rd_chk(art_pkg::IDX_COUNTER, 8'hfe);
      wr(art_pkg::IDX_CTRL_STATUS, 8'h80);
      farPins.event_pulses(2);
      rd_chk(art_pkg::IDX_COUNTER, 8'hfe);
      // PWM over two full periods and part of a third, duty changed mid-period
      for (int i = 0; i < 4; i++) wr(8'h76 - i[7:0], duty[i]);
      wr(art_pkg::IDX_RELOAD, 8'hfc);
      wr(art_pkg::IDX_PULSE_CTRL, {4'hf, pol});
      wr(art_pkg::IDX_CTRL_STATUS, 8'h8c);
      cnt = 8'hfc;
      check_pins(modulatedOutputPin, pwm_exp(cnt));
      check_pins(modulatedOutputOeN, 4'h0);
      for (int k = 0; k < 9; k++) begin
         if (k == 5) begin
            duty[0] = 8'hfc;
            wr(art_pkg::IDX_DUTY0, duty[0]);
         end
         farPins.event_pulses(1);
         if (cnt == art_pkg::COUNT_TOP) begin
            cnt = 8'hfc;
            cmp = duty;
         end else begin
            cnt++;
         end
         check_pins(modulatedOutputPin, pwm_exp(cnt));
      end
      haltMode <= 1'b1;
      farPins.event_pulses(1);
      check_pins(modulatedOutputPin, pwm_exp(cnt));
      rd_chk(art_pkg::IDX_COUNTER, cnt);
      haltMode <= 1'b0;
      wr(art_pkg::IDX_PULSE_CTRL, {4'h3, pol});
      // Output enable pins follow the pulse control register one cycle later
      @(posedge sys_clk);
      check_pins(modulatedOutputOeN, 4'hc);
      // Captures: channel one rising, channel two falling
      wr(art_pkg::IDX_CTRL_STATUS, 8'h00);
      wr(art_pkg::IDX_COUNTER, 8'h42);
      wr(art_pkg::IDX_CAP_CTRL, 8'h1c);
      farPins.drive_capture(0, 1'b1);
      rd_chk(art_pkg::IDX_CAP_CTRL, 8'h1d);
      check_pins({3'h0, captureIrq}, 4'h1);
      farPins.drive_capture(0, 1'b0);
      wr(art_pkg::IDX_COUNTER, 8'h43);
      farPins.drive_capture(1, 1'b0);
      rd_chk(art_pkg::IDX_CAP_CTRL, 8'h1f);
      wr(art_pkg::IDX_COUNTER, 8'h44);
      farPins.drive_capture(0, 1'b1);
      rd_chk(art_pkg::IDX_CAP1, 8'h42);
      rd_chk(art_pkg::IDX_CAP2, 8'h43);
      farPins.drive_capture(1, 1'b1);
      rd_chk(art_pkg::IDX_CAP_CTRL, 8'h1c);
      check_pins({3'h0, captureIrq}, 4'h0);
      haltMode <= 1'b1;
      farPins.drive_capture(0, 1'b0);
      farPins.drive_capture(0, 1'b1);
      check_pins({3'h0, wakeRequest}, 4'h1);
      haltMode <= 1'b0;
      rd_chk(art_pkg::IDX_CAP1, 8'h44);
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
